// ==== logic/romc_pkg.sv ====
package romc_pkg;

    // Operating modes, Gray-coded along sleep, standby, synthesiser and active modes.
    typedef enum logic [2:0] {
        ROMC_SLEEP     = 3'h0,
        ROMC_STANDBY   = 3'h1,
        ROMC_TX_SYNTH  = 3'h3,
        ROMC_TX        = 3'h2,
        ROMC_RX_SYNTH  = 3'h6,
        ROMC_RX_CONT   = 3'h7,
        ROMC_RX_SINGLE = 3'h5,
        ROMC_CAD       = 3'h4
    } romc_mode_t;

    // Register addresses on the serial port.
    localparam logic [6:0] ADDR_FIFO   = 7'h00;
    localparam logic [6:0] ADDR_OPMODE = 7'h01;
    localparam logic [6:0] ADDR_MAP_LO = 7'h10;
    localparam logic [6:0] ADDR_MAP_HI = 7'h11;
    localparam logic [6:0] ADDR_STATUS = 7'h12;

    // Frame layout.
    localparam int         WRITE_BIT   = 7;
    localparam logic [4:0] CNT_ADDR    = 5'h07;
    localparam logic [4:0] CNT_LOAD    = 5'h08;
    localparam logic [4:0] CNT_DATA    = 5'h0F;
    localparam logic [4:0] FRAME_BITS  = 5'h10;

    // Operating-mode register fields and reset value.
    localparam int         LR_BIT      = 7;
    localparam int         MODE_MSB    = 2;
    localparam logic [7:0] OPMODE_RST  = 8'h01;

    // Event pin map fields and reset value.
    localparam int         PIN0_LSB    = 6;
    localparam int         PIN1_LSB    = 4;
    localparam int         PIN2_LSB    = 2;
    localparam int         PIN3_LSB    = 0;
    localparam int         PIN4_LSB    = 6;
    localparam int         PIN5_LSB    = 4;
    localparam logic [7:0] MAP_RST     = 8'h00;
    localparam logic [1:0] EV_CODE_0   = 2'h0;
    localparam logic [1:0] EV_CODE_1   = 2'h1;
    localparam logic [1:0] EV_CODE_2   = 2'h2;

    // Status register fields.
    localparam int         ST_CAD_FOUND  = 0;
    localparam int         ST_CRC_ERR    = 1;
    localparam int         ST_MODE_READY = 2;

    // Packet engine.
    localparam int          FIFO_DEPTH = 256;
    localparam logic [8:0]  FIFO_FULL  = 9'h100;
    localparam logic [15:0] CRC_POLY   = 16'h1021;
    localparam logic [15:0] CRC_INIT   = 16'hFFFF;

endpackage

// ==== logic/romc_sync.sv ====
`timescale 1ns/1ps
module romc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Two-stage synchroniser; the first stage feeds only the second.
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // romc_sync

// ==== logic/romc_top.sv ====
`timescale 1ns/1ps
module romc_top
    import romc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        spi_clock,
    input  wire logic        spi_select_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        rx_packet_valid,
    input  wire logic        rx_crc_failed,
    input  wire logic        rx_header_valid,
    input  wire logic        rx_timed_out,
    input  wire logic        tx_packet_sent,
    input  wire logic        cad_finished,
    input  wire logic        cad_found,
    input  wire logic        pll_locked,
    output logic             osc_enable,
    output logic             baseband_enable,
    output logic             pll_tx_enable,
    output logic             pll_rx_enable,
    output logic             rf_tx_enable,
    output logic             rf_rx_enable,
    output logic             pa_enable,
    output logic             cad_enable,
    output logic             long_range_active,
    output logic             event_pin_0,
    output logic             event_pin_1,
    output logic             event_pin_2,
    output logic             event_pin_3,
    output logic             event_pin_4,
    output logic             event_pin_5,
    output logic [8:0]       payload_length,
    output logic [15:0]      crc_value
);

    logic [4:0]  bit_cnt_q;
    logic [6:0]  shift_q;
    logic [7:0]  cap_addr_q;
    logic [7:0]  cap_data_q;
    logic        cap_tog_q;
    logic [7:0]  out_q;
    logic [7:0]  read_byte;
    logic        sel_n_s;
    logic        sel_n_d_q;
    logic        tog_s;
    logic        tog_seen_q;
    logic        pend_q;
    logic        pend_wr_q;
    logic [6:0]  pend_addr_q;
    logic [7:0]  pend_data_q;
    romc_mode_t  mode_q;
    logic        lr_q;
    logic [7:0]  map_lo_q;
    logic [7:0]  map_hi_q;
    logic        cad_found_q;
    logic        crc_err_q;
    logic [8:0]  wr_ptr_q;
    logic [7:0]  rd_ptr_q;
    logic [15:0] crc_q;
    logic [7:0]  fifo_mem_q [FIFO_DEPTH];
    logic [7:0]  snap_op_q;
    logic [7:0]  snap_lo_q;
    logic [7:0]  snap_hi_q;
    logic [7:0]  snap_st_q;
    logic [7:0]  snap_fifo_q;
    logic        clk_out_q;
    logic        word_ev;
    logic        frame_end;
    logic        apply;
    logic        op_wr;
    logic        fifo_access;
    logic        fifo_wr_ok;
    logic        fifo_rd_ok;
    logic        auto_stby;
    logic        rx_good;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic pick(input logic [1:0] code, input logic a, input logic b,
                                  input logic c);
        return (code == EV_CODE_0) ? a : (code == EV_CODE_1) ? b : (code == EV_CODE_2) ? c : 1'b0;
    endfunction

    // Serial link domain: bit counter cleared while chip select is high.
    always_ff @(posedge spi_clock or posedge spi_select_n) begin
        if (spi_select_n) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge spi_clock) begin
        shift_q <= {shift_q[5:0], spi_mosi};
    end

    always_ff @(posedge spi_clock) begin
        if (bit_cnt_q == CNT_ADDR) begin
            cap_addr_q <= {shift_q, spi_mosi};
        end
        if (bit_cnt_q == CNT_DATA) begin
            cap_data_q <= {shift_q, spi_mosi};
        end
    end

    // Toggle announces a complete address and data word to the core domain.
    always_ff @(posedge spi_clock or posedge rst) begin
        if (rst) begin
            cap_tog_q <= 1'b0;
        end else if (bit_cnt_q == CNT_DATA) begin
            cap_tog_q <= ~cap_tog_q;
        end
    end

    // Snapshot registers are frozen while a frame is active, so they are stable here.
    always_comb begin
        case (cap_addr_q[6:0])
            ADDR_FIFO:   read_byte = snap_fifo_q;
            ADDR_OPMODE: read_byte = snap_op_q;
            ADDR_MAP_LO: read_byte = snap_lo_q;
            ADDR_MAP_HI: read_byte = snap_hi_q;
            ADDR_STATUS: read_byte = snap_st_q;
            default:     read_byte = 8'h00;
        endcase
    end

    // Half-duplex read data shifted out on the falling edge.
    always_ff @(negedge spi_clock or posedge rst) begin
        if (rst) begin
            out_q <= 8'h00;
        end else if (bit_cnt_q == CNT_LOAD) begin
            out_q <= cap_addr_q[WRITE_BIT] ? 8'h00 : read_byte;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign spi_miso = out_q[7];

    // Crossings into the core domain.
    romc_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_sel (
        .clock    (clock),
        .rst      (rst),
        .async_in (spi_select_n),
        .sync_out (sel_n_s)
    );

    romc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_tog (
        .clock    (clock),
        .rst      (rst),
        .async_in (cap_tog_q),
        .sync_out (tog_s)
    );

    assign word_ev     = tog_s ^ tog_seen_q;
    assign frame_end   = sel_n_s & ~sel_n_d_q;
    assign apply       = frame_end & pend_q;
    assign op_wr       = apply & pend_wr_q & (pend_addr_q == ADDR_OPMODE);
    assign fifo_access = apply & (pend_addr_q == ADDR_FIFO);
    assign fifo_wr_ok  = fifo_access & pend_wr_q & (mode_q != ROMC_SLEEP)
                       & (wr_ptr_q != FIFO_FULL);
    assign fifo_rd_ok  = fifo_access & ~pend_wr_q & (mode_q != ROMC_SLEEP);
    assign rx_good     = rx_packet_valid & ~rx_crc_failed;
    assign auto_stby   = ((mode_q == ROMC_TX) & tx_packet_sent)
                       | ((mode_q == ROMC_RX_SINGLE) & rx_good)
                       | ((mode_q == ROMC_CAD) & cad_finished);

    always_ff @(posedge clock) begin
        if (rst) begin
            sel_n_d_q  <= 1'b1;
            tog_seen_q <= 1'b0;
        end else begin
            sel_n_d_q  <= sel_n_s;
            tog_seen_q <= tog_s;
        end
    end

    // Word held pending until chip select rises; a new word wins over the clear.
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_q      <= 1'b0;
            pend_wr_q   <= 1'b0;
            pend_addr_q <= 7'h00;
            pend_data_q <= 8'h00;
        end else if (word_ev) begin
            pend_q      <= 1'b1;
            pend_wr_q   <= cap_addr_q[WRITE_BIT];
            pend_addr_q <= cap_addr_q[6:0];
            pend_data_q <= cap_data_q;
        end else if (frame_end) begin
            pend_q      <= 1'b0;
        end
    end

    // Operating mode: host write at frame end, else automatic return to standby.
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= romc_mode_t'(OPMODE_RST[MODE_MSB:0]);
            lr_q   <= OPMODE_RST[LR_BIT];
        end else if (op_wr) begin
            mode_q <= romc_mode_t'(pend_data_q[MODE_MSB:0]);
            if (mode_q == ROMC_SLEEP) begin
                lr_q <= pend_data_q[LR_BIT];
            end
        end else if (auto_stby) begin
            mode_q <= ROMC_STANDBY;
        end
    end

    // Configuration registers stay writable in every mode, sleep included.
    always_ff @(posedge clock) begin
        if (rst) begin
            map_lo_q <= MAP_RST;
            map_hi_q <= MAP_RST;
        end else if (apply & pend_wr_q) begin
            if (pend_addr_q == ADDR_MAP_LO) begin
                map_lo_q <= pend_data_q;
            end
            if (pend_addr_q == ADDR_MAP_HI) begin
                map_hi_q <= pend_data_q;
            end
        end
    end

    // Status: detection outcome and CRC error; writing the status register clears the CRC error, entering detection clears the outcome.
    always_ff @(posedge clock) begin
        if (rst) begin
            cad_found_q <= 1'b0;
            crc_err_q   <= 1'b0;
        end else begin
            if ((mode_q == ROMC_CAD) & cad_finished) begin
                cad_found_q <= cad_found;
            end else if (op_wr & (pend_data_q[MODE_MSB:0] == ROMC_CAD)) begin
                cad_found_q <= 1'b0;
            end
            if (rx_packet_valid & rx_crc_failed) begin
                crc_err_q <= 1'b1;
            end else if (apply & pend_wr_q & (pend_addr_q == ADDR_STATUS)) begin
                crc_err_q <= 1'b0;
            end
        end
    end

    // Packet engine: payload store, length and running CRC.
    always_ff @(posedge clock) begin
        if (fifo_wr_ok) begin
            fifo_mem_q[wr_ptr_q[7:0]] <= pend_data_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_q <= 9'h000;
            rd_ptr_q <= 8'h00;
            crc_q    <= CRC_INIT;
        end else if ((mode_q == ROMC_TX) & tx_packet_sent) begin
            wr_ptr_q <= 9'h000;
            rd_ptr_q <= 8'h00;
            crc_q    <= CRC_INIT;
        end else begin
            if (fifo_wr_ok) begin
                wr_ptr_q <= wr_ptr_q + 9'h001;
                crc_q    <= crc_byte(crc_q, pend_data_q);
            end
            if (fifo_rd_ok) begin
                rd_ptr_q <= rd_ptr_q + 8'h01;
            end
        end
    end

    // Read snapshot, refreshed only while no frame is active.
    always_ff @(posedge clock) begin
        if (rst) begin
            snap_op_q   <= OPMODE_RST;
            snap_lo_q   <= MAP_RST;
            snap_hi_q   <= MAP_RST;
            snap_st_q   <= 8'h00;
            snap_fifo_q <= 8'h00;
        end else if (sel_n_s) begin
            snap_op_q   <= {lr_q, 4'h0, mode_q};
            snap_lo_q   <= map_lo_q;
            snap_hi_q   <= map_hi_q;
            snap_st_q   <= {5'h00, (mode_q == ROMC_STANDBY), crc_err_q, cad_found_q};
            snap_fifo_q <= (mode_q == ROMC_SLEEP) ? 8'h00 : fifo_mem_q[rd_ptr_q];
        end
    end

    // Block enables follow the mode; the modem select follows lr_q and the read-data enable follows chip select.
    always_ff @(posedge clock) begin
        if (rst) begin
            osc_enable        <= 1'b0;
            baseband_enable   <= 1'b0;
            pll_tx_enable     <= 1'b0;
            pll_rx_enable     <= 1'b0;
            rf_tx_enable      <= 1'b0;
            rf_rx_enable      <= 1'b0;
            pa_enable         <= 1'b0;
            cad_enable        <= 1'b0;
            long_range_active <= 1'b0;
            spi_miso_oe       <= 1'b0;
        end else begin
            osc_enable        <= mode_q != ROMC_SLEEP;
            baseband_enable   <= mode_q != ROMC_SLEEP;
            pll_tx_enable     <= (mode_q == ROMC_TX_SYNTH) | (mode_q == ROMC_TX);
            pll_rx_enable     <= (mode_q == ROMC_RX_SYNTH) | (mode_q == ROMC_RX_CONT)
                               | (mode_q == ROMC_RX_SINGLE) | (mode_q == ROMC_CAD);
            rf_tx_enable      <= mode_q == ROMC_TX;
            pa_enable         <= mode_q == ROMC_TX;
            rf_rx_enable      <= (mode_q == ROMC_RX_CONT) | (mode_q == ROMC_RX_SINGLE)
                               | (mode_q == ROMC_CAD);
            cad_enable        <= mode_q == ROMC_CAD;
            long_range_active <= lr_q;
            spi_miso_oe       <= ~sel_n_s;
        end
    end

    // Event pins routed by the map fields.
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_out_q   <= 1'b0;
            event_pin_0 <= 1'b0;
            event_pin_1 <= 1'b0;
            event_pin_2 <= 1'b0;
            event_pin_3 <= 1'b0;
            event_pin_4 <= 1'b0;
            event_pin_5 <= 1'b0;
        end else begin
            clk_out_q   <= ~clk_out_q;
            event_pin_0 <= pick(map_lo_q[PIN0_LSB+:2], rx_packet_valid, tx_packet_sent,
                                cad_finished);
            event_pin_1 <= pick(map_lo_q[PIN1_LSB+:2], rx_timed_out, 1'b0,
                                cad_finished & cad_found);
            event_pin_2 <= pick(map_lo_q[PIN2_LSB+:2], 1'b0, 1'b0, 1'b0);
            event_pin_3 <= pick(map_lo_q[PIN3_LSB+:2], cad_finished, rx_header_valid,
                                rx_packet_valid & rx_crc_failed);
            event_pin_4 <= pick(map_hi_q[PIN4_LSB+:2], cad_finished & cad_found, pll_locked,
                                pll_locked);
            event_pin_5 <= pick(map_hi_q[PIN5_LSB+:2], mode_q == ROMC_STANDBY, clk_out_q,
                                clk_out_q);
        end
    end

    assign payload_length = wr_ptr_q;
    assign crc_value      = crc_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_tx_done;
        (mode_q == ROMC_TX) && tx_packet_sent && !op_wr;
    endsequence
    sequence s_rx_done;
        (mode_q == ROMC_RX_SINGLE) && rx_good && !op_wr;
    endsequence

    property p_mode_write;
        op_wr |=> mode_q == romc_mode_t'($past(pend_data_q[MODE_MSB:0]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not taken from write");
    property p_long_range;
        op_wr && mode_q == ROMC_SLEEP |=> lr_q == $past(pend_data_q[LR_BIT])
                                          ##1 long_range_active == $past(lr_q);
    endproperty
    a_long_range: assert property (p_long_range) else $error("modem select not applied");
    property p_fifo_grow;
        fifo_wr_ok && !(mode_q == ROMC_TX && tx_packet_sent)
            |=> wr_ptr_q == $past(wr_ptr_q) + 9'h001;
    endproperty
    a_fifo_grow: assert property (p_fifo_grow) else $error("payload length not advanced");
    property p_map_sleep;
        apply && pend_wr_q && pend_addr_q == ADDR_MAP_LO |=> map_lo_q == $past(pend_data_q);
    endproperty
    a_map_sleep: assert property (p_map_sleep) else $error("map register not written");
    property p_fifo_sleep;
        fifo_access && mode_q == ROMC_SLEEP |=> $stable(wr_ptr_q) && $stable(rd_ptr_q);
    endproperty
    a_fifo_sleep: assert property (p_fifo_sleep) else $error("fifo touched in sleep");
    property p_lr_sleep_only;
        $changed(lr_q) |-> $past(mode_q) == ROMC_SLEEP && $past(op_wr);
    endproperty
    a_lr_sleep_only: assert property (p_lr_sleep_only) else $error("modem select changed");
    property p_standby;
        !rst && mode_q == ROMC_STANDBY |=> osc_enable && baseband_enable && !pll_tx_enable
                                   && !pll_rx_enable && !rf_tx_enable && !rf_rx_enable;
    endproperty
    a_standby: assert property (p_standby) else $error("standby enables wrong");
    property p_tx_synth;
        mode_q == ROMC_TX_SYNTH |=> pll_tx_enable && !pll_rx_enable && !rf_tx_enable && !pa_enable;
    endproperty
    a_tx_synth: assert property (p_tx_synth) else $error("tx synth enables wrong");
    property p_rx_synth;
        mode_q == ROMC_RX_SYNTH |=> pll_rx_enable && !pll_tx_enable && !rf_rx_enable;
    endproperty
    a_rx_synth: assert property (p_rx_synth) else $error("rx synth enables wrong");
    property p_tx_return;
        s_tx_done |=> mode_q == ROMC_STANDBY ##1 !pa_enable;
    endproperty
    a_tx_return: assert property (p_tx_return) else $error("no standby after transmit");
    property p_rx_cont;
        mode_q == ROMC_RX_CONT && !op_wr |=> mode_q == ROMC_RX_CONT && rf_rx_enable;
    endproperty
    a_rx_cont: assert property (p_rx_cont) else $error("continuous receive left");
    property p_rx_single;
        s_rx_done |=> mode_q == ROMC_STANDBY;
    endproperty
    a_rx_single: assert property (p_rx_single) else $error("no standby after receive");
    property p_cad;
        mode_q == ROMC_CAD && cad_finished |=> cad_found_q == $past(cad_found);
    endproperty
    a_cad: assert property (p_cad) else $error("detection outcome lost");
    property p_pin0;
        map_lo_q[PIN0_LSB+:2] == EV_CODE_0 && rx_packet_valid |=> event_pin_0;
    endproperty
    a_pin0: assert property (p_pin0) else $error("receive done not on pin 0");
    property p_frame_end;
        !$past(frame_end) && !$past(auto_stby) |-> $stable(mode_q);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("mode changed mid frame");
    property p_readback;
        s_tx_done ##1 (sel_n_s && !op_wr) |=> snap_op_q[MODE_MSB:0] == ROMC_STANDBY;
    endproperty
    a_readback: assert property (p_readback) else $error("standby not read back");

endmodule // romc_top

// ==== verif/romc_host.sv ====
`timescale 1ns/1ps
module romc_host (
    output logic      spi_clock,
    output logic      spi_select_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_clock = 1'b0;
        spi_select_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Sends one address byte and one data byte MSB first; the clock idles low.
    task automatic xfer(input logic [15:0] w, output logic [7:0] r);
        spi_select_n = 1'b0;
        #30;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = w[i];
            #3;
            if (i < 8) r[i] = spi_miso;
            spi_clock = 1'b1;
            #3;
            spi_clock = 1'b0;
        end
        #100;
        spi_select_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #150;
    endtask
endmodule // romc_host

// ==== verif/romc_top_tb.sv ====
`timescale 1ns/1ps
module romc_top_tb
    import romc_pkg::*;
;
    logic            clock;
    logic            rst;
    logic [7:0]      ev;
    logic [7:0]      r;
    int              errors = 0;
    int              n_compared = 0;
    int              cycles = 0;
    wire logic [5:0] irq;
    wire logic [6:0] en;
    wire logic [8:0] len;
    wire logic       lr;
    wire logic       sck;
    wire logic       sel_n;
    wire logic       mosi;
    wire logic       miso;
    wire logic       oe;
    wire logic       bb;
    wire logic [15:0] crc;
    // Expected {osc, tx pll, rx pll, tx rf, rx rf, amplifier, detect} per mode code.
    logic [6:0] exp_en [8] = '{7'h00, 7'h40, 7'h6A, 7'h60, 7'h55, 7'h54, 7'h50, 7'h54};

    romc_host i_romc_host (.spi_clock(sck), .spi_select_n(sel_n), .spi_mosi(mosi),
        .spi_miso(miso));
    romc_top i_romc_top (.clock(clock), .rst(rst), .spi_clock(sck), .spi_select_n(sel_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .rx_packet_valid(ev[0]),
        .rx_crc_failed(ev[1]), .rx_header_valid(ev[2]), .rx_timed_out(ev[3]),
        .tx_packet_sent(ev[4]), .cad_finished(ev[5]), .cad_found(ev[6]), .pll_locked(ev[7]),
        .osc_enable(en[6]), .baseband_enable(bb), .pll_tx_enable(en[5]),
        .pll_rx_enable(en[4]), .rf_tx_enable(en[3]), .rf_rx_enable(en[2]),
        .pa_enable(en[1]), .cad_enable(en[0]), .long_range_active(lr),
        .event_pin_0(irq[0]), .event_pin_1(irq[1]), .event_pin_2(irq[2]),
        .event_pin_3(irq[3]), .event_pin_4(irq[4]), .event_pin_5(irq[5]),
        .payload_length(len), .crc_value(crc));

    task automatic complete_run;
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_romc_host.xfer({1'b1, a, d}, r);
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        fork
            i_romc_host.xfer({1'b0, a, 8'h00}, r);
            #90 chk(oe, 1'b1);
        join
        chk(r, e);
        chk(oe, 1'b0);
    endtask
    task automatic pulse(input logic [7:0] m, input logic [5:0] x);
        @(posedge clock) ev <= m;
        @(posedge clock) ev <= 8'h00;
        #1 chk(irq, x);
    endtask
    task automatic see(input logic [2:0] m);
        repeat (2) @(posedge clock);
        #1 chk(en, exp_en[m]);
        chk(bb, m != 3'h0);
        chk(irq[5], m == 3'h1);
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end

    initial begin
        rst = 1'b1;
        ev = 8'h00;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        see(3'h1);
        rd(ADDR_OPMODE, OPMODE_RST);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_OPMODE, 8'(m));
            see(3'(m));
            rd(ADDR_OPMODE, 8'(m));
        end
        pulse(8'h01, 6'h01);
        see(3'h7);
        wr(ADDR_MAP_LO, 8'h40);
        wr(ADDR_OPMODE, 8'h02);
        pulse(8'h10, 6'h01);
        see(3'h1);
        rd(ADDR_OPMODE, 8'h01);
        wr(ADDR_MAP_LO, 8'h02);
        wr(ADDR_OPMODE, 8'h05);
        pulse(8'h03, 6'h09);
        see(3'h5);
        pulse(8'h01, 6'h01);
        see(3'h1);
        rd(ADDR_OPMODE, 8'h01);
        wr(ADDR_MAP_LO, 8'hA0);
        wr(ADDR_OPMODE, 8'h04);
        pulse(8'h60, 6'h1B);
        see(3'h1);
        rd(ADDR_STATUS, 8'h07);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h05);
        wr(ADDR_OPMODE, 8'h81);
        chk(lr, 1'b0);
        wr(ADDR_OPMODE, 8'h00);
        wr(ADDR_OPMODE, 8'h80);
        chk(lr, 1'b1);
        wr(ADDR_MAP_HI, 8'h50);
        rd(ADDR_MAP_HI, 8'h50);
        wr(ADDR_FIFO, 8'hA5);
        chk(len, 9'h000);
        rd(ADDR_FIFO, 8'h00);
        wr(ADDR_OPMODE, 8'h81);
        rd(ADDR_OPMODE, 8'h81);
        wr(ADDR_FIFO, 8'h00);
        chk(len, 9'h001);
        chk(crc, 16'hE1F0);
        for (int i = 0; i < 256; i++) begin
            wr(ADDR_FIFO, 8'(i));
        end
        chk(len, FIFO_FULL);
        complete_run();
    end
endmodule // romc_top_tb
